// ---- hw/reset_pin_qualifier.sv ----
// reset pin synchroniser and minimum-width qualifier
`timescale 1ns/1ps
`default_nettype none
module reset_pin_qualifier #(
    parameter int MIN_LOW_CYC = strap_pkg::RESET_MIN_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic resetPinN,
    strap_if.qualifier ifc
);
    import strap_pkg::*;
    localparam int CNT_W = $clog2(MIN_LOW_CYC + 1);
    typedef enum logic [1:0] {
        ST_POR = 2'h0,
        ST_HOLD = 2'h1,
        ST_CAPT = 2'h3,
        ST_RUN = 2'h2
    } qual_state_t;

    logic [1:0] pinSync_q;
    qual_state_t state_q, state_d;
    logic [CNT_W-1:0] lowCnt_q, lowCnt_d;
    logic pinLow;

    assign pinLow = !pinSync_q[1];

    always_comb begin
        state_d = state_q;
        lowCnt_d = '0;
        case (state_q)
            ST_POR: begin
                lowCnt_d = lowCnt_q + 1'b1;
                if (lowCnt_q == CNT_W'(STRAP_SETTLE_CYC - 1)) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!pinLow) begin
                    state_d = ST_CAPT;
                end
            end
            ST_CAPT: state_d = ST_RUN;
            ST_RUN: begin
                // glitches shorter than the minimum width are ignored
                if (pinLow) begin
                    lowCnt_d = lowCnt_q + 1'b1;
                    if (lowCnt_q == CNT_W'(MIN_LOW_CYC - 1)) begin
                        state_d = ST_HOLD;
                    end
                end
            end
            default: state_d = ST_POR;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pinSync_q <= PIN_SYNC_RST;
            state_q <= ST_POR;
            lowCnt_q <= '0;
        end else begin
            pinSync_q <= {pinSync_q[0], resetPinN};
            state_q <= state_d;
            lowCnt_q <= lowCnt_d;
        end
    end

    assign ifc.hwResetActive = (state_q != ST_RUN);
    assign ifc.captureStb = (state_q == ST_CAPT);

    rst_qualify_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        (state_q == ST_RUN) ##1 (state_q == ST_HOLD) |-> $past(lowCnt_q) == CNT_W'(MIN_LOW_CYC - 1))
        else $error("reset accepted without minimum low width");
    glitch_ignore_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        (state_q == ST_RUN) && !pinLow |=> (state_q == ST_RUN) && (lowCnt_q == '0))
        else $error("high reset pin left run state");
endmodule
`default_nettype wire

// ---- hw/reset_powerdown_strap_latch.sv ----
// reset, power-down or interrupt pin and strap-derived control registers
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module reset_powerdown_strap_latch (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic resetPinN,
    input wire logic [strap_pkg::STRAP_ADDR_W-1:0] stationAddrStrap,
    input wire logic autonegEnableStrap,
    input wire logic modeSelectStrapHi,
    input wire logic modeSelectStrapLo,
    input wire logic fiberEnableLowStrap,
    input wire logic powerdownOrIrqPinIn,
    output logic powerdownOrIrqPinOut,
    output logic powerdownOrIrqPinOeN,
    input wire logic irqPending,
    input wire logic [strap_pkg::REG_ADDR_W-1:0] regAddr,
    input wire logic [strap_pkg::REG_DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [strap_pkg::REG_DATA_W-1:0] regRdata,
    output logic chipInReset,
    output logic powerDown,
    output logic isolate,
    output logic autonegEnable,
    output logic speed100,
    output logic fullDuplex,
    output logic fiberMode,
    output logic [strap_pkg::STRAP_ADDR_W-1:0] stationAddr
);
    import strap_pkg::*;

    strap_if ifc ();

    reset_pin_qualifier u_qual (
        .clk(clk),
        .arst_n(arst_n),
        .resetPinN(resetPinN),
        .ifc(ifc.qualifier)
    );

    strap_capture u_cap (
        .clk(clk),
        .arst_n(arst_n),
        .stationAddrStrap(stationAddrStrap),
        .autonegEnableStrap(autonegEnableStrap),
        .modeSelectStrapHi(modeSelectStrapHi),
        .modeSelectStrapLo(modeSelectStrapLo),
        .fiberEnableLowStrap(fiberEnableLowStrap),
        .ifc(ifc.capture)
    );

    logic [1:0] pdSync_q;
    logic speed_q, speed_d, anEn_q, anEn_d, pdBit_q, pdBit_d;
    logic iso_q, iso_d, duplex_q, duplex_d, irqMode_q, irqMode_d;
    logic fiber_q, fiber_d;
    logic [ADV_W-1:0] adv_q, adv_d;
    logic [STRAP_ADDR_W-1:0] addr_q, addr_d;
    logic powerDown_q, powerDown_d, pinOeN_q, pinOeN_d, pinOut_q, pinOut_d;
    logic inReset_q, inReset_d;
    logic [REG_DATA_W-1:0] rdata_q, rdata_d;
    logic swReset;
    logic strapAnEn, strapSpeed, strapDuplex, strapIso;
    logic [ADV_W-1:0] strapAdv;

    assign swReset = regWrite && (regAddr == ADDR_BMCR) && regWdata[BMCR_RESET_BIT];

    // values a strap load or a software reset puts into the registers
    always_comb begin
        strapAnEn = ifc.capFxN && ifc.capAnEn;
        strapSpeed = ifc.capFxN ? ifc.capSelHi : 1'b1;
        strapDuplex = ifc.capSelLo;
        strapIso = (ifc.capAddr == '0);
        strapAdv = advertiseFor(ifc.capFxN, ifc.capSelHi, ifc.capSelLo);
    end

    always_comb begin
        speed_d = speed_q;
        anEn_d = anEn_q;
        pdBit_d = pdBit_q;
        iso_d = iso_q;
        duplex_d = duplex_q;
        irqMode_d = irqMode_q;
        fiber_d = fiber_q;
        adv_d = adv_q;
        addr_d = addr_q;
        if (ifc.hwResetActive) begin
            speed_d = 1'b0;
            anEn_d = 1'b0;
            pdBit_d = 1'b0;
            iso_d = 1'b0;
            duplex_d = 1'b0;
            irqMode_d = 1'b0;
            fiber_d = 1'b0;
            adv_d = '0;
            addr_d = '0;
        end else if (ifc.strapLoad || swReset) begin
            // software reset reuses the last capture, pins are not looked at
            speed_d = strapSpeed;
            anEn_d = strapAnEn;
            pdBit_d = 1'b0;
            iso_d = strapIso;
            duplex_d = strapDuplex;
            irqMode_d = 1'b0;
            fiber_d = !ifc.capFxN;
            adv_d = strapAdv;
            addr_d = ifc.capAddr;
        end else if (regWrite) begin
            // power-down never gates the register port
            case (regAddr)
                ADDR_BMCR: begin
                    speed_d = fiber_q ? 1'b1 : regWdata[BMCR_SPEED_BIT];
                    anEn_d = fiber_q ? 1'b0 : regWdata[BMCR_ANEN_BIT];
                    pdBit_d = regWdata[BMCR_PWRDN_BIT];
                    iso_d = regWdata[BMCR_ISO_BIT];
                    duplex_d = regWdata[BMCR_DUPLEX_BIT];
                end
                ADDR_ANAR: adv_d = regWdata[ANAR_CAP_LSB +: ADV_W];
                ADDR_INTCTL: irqMode_d = regWdata[INT_PIN_MODE_BIT];
                // address change alone never touches isolation
                ADDR_PHY_CONTROL: addr_d = regWdata[STRAP_ADDR_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // pin outputs and status levels
    always_comb begin
        inReset_d = ifc.hwResetActive;
        powerDown_d = !ifc.hwResetActive &&
                      (pdBit_q || (!irqMode_q && !pdSync_q[1]));
        // open-drain style: only ever pulls low, released otherwise
        pinOeN_d = !(irqMode_q && irqPending);
        pinOut_d = !(irqMode_q && irqPending);
    end

    always_comb begin
        rdata_d = '0;
        if (regRead) begin
            case (regAddr)
                ADDR_BMCR: begin
                    rdata_d[BMCR_SPEED_BIT] = speed_q;
                    rdata_d[BMCR_ANEN_BIT] = anEn_q;
                    rdata_d[BMCR_PWRDN_BIT] = pdBit_q;
                    rdata_d[BMCR_ISO_BIT] = iso_q;
                    rdata_d[BMCR_DUPLEX_BIT] = duplex_q;
                end
                ADDR_ANAR: begin
                    rdata_d[ANAR_SEL_LSB +: ANAR_SEL_W] = ANAR_SEL;
                    rdata_d[ANAR_CAP_LSB +: ADV_W] = adv_q;
                end
                ADDR_STATUS: begin
                    rdata_d[STAT_FIBER_BIT] = fiber_q;
                    rdata_d[STAT_PD_BIT] = powerDown_q;
                    rdata_d[STAT_PDPIN_BIT] = pdSync_q[1];
                    rdata_d[STAT_IRQ_BIT] = irqPending;
                    rdata_d[STAT_RESET_BIT] = inReset_q;
                    rdata_d[STAT_ADDR_LSB +: STRAP_ADDR_W] = ifc.capAddr;
                end
                ADDR_INTCTL: rdata_d[INT_PIN_MODE_BIT] = irqMode_q;
                ADDR_PHY_CONTROL: rdata_d[STRAP_ADDR_W-1:0] = addr_q;
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pdSync_q <= PIN_SYNC_RST;
            speed_q <= 1'b0;
            anEn_q <= 1'b0;
            pdBit_q <= 1'b0;
            iso_q <= 1'b0;
            duplex_q <= 1'b0;
            irqMode_q <= 1'b0;
            fiber_q <= 1'b0;
            adv_q <= '0;
            addr_q <= '0;
            powerDown_q <= 1'b0;
            pinOeN_q <= 1'b1;
            pinOut_q <= 1'b1;
            inReset_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            pdSync_q <= {pdSync_q[0], powerdownOrIrqPinIn};
            speed_q <= speed_d;
            anEn_q <= anEn_d;
            pdBit_q <= pdBit_d;
            iso_q <= iso_d;
            duplex_q <= duplex_d;
            irqMode_q <= irqMode_d;
            fiber_q <= fiber_d;
            adv_q <= adv_d;
            addr_q <= addr_d;
            powerDown_q <= powerDown_d;
            pinOeN_q <= pinOeN_d;
            pinOut_q <= pinOut_d;
            inReset_q <= inReset_d;
            rdata_q <= rdata_d;
        end
    end

    assign regRdata = rdata_q;
    assign chipInReset = inReset_q;
    assign powerDown = powerDown_q;
    assign isolate = iso_q;
    assign autonegEnable = anEn_q;
    assign speed100 = speed_q;
    assign fullDuplex = duplex_q;
    assign fiberMode = fiber_q;
    assign stationAddr = addr_q;
    assign powerdownOrIrqPinOeN = pinOeN_q;
    assign powerdownOrIrqPinOut = pinOut_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    hw_defaults_a: assert property (
        ifc.hwResetActive ##1 ifc.hwResetActive |-> !anEn_q && !pdBit_q && !iso_q &&
        !irqMode_q && (addr_q == '0) && (adv_q == '0) && !powerDown_q)
        else $error("register not at default during hardware reset");

    strap_apply_a: assert property (
        ifc.strapLoad |=> (addr_q == $past(ifc.capAddr)) && (fiber_q == !$past(ifc.capFxN)))
        else $error("strap values not applied after capture");

    pd_pin_a: assert property (
        !irqMode_q && !pdSync_q[1] && !ifc.hwResetActive |=> powerDown_q)
        else $error("power-down pin low did not power down");

    pin_release_a: assert property (
        !irqMode_q |=> pinOeN_q)
        else $error("pin driven while in power-down input mode");

    pin_level_a: assert property (
        !irqMode_q |=> pinOut_q)
        else $error("pin value low while not in interrupt mode");

    irq_mode_pd_a: assert property (
        irqMode_q && !pdBit_q |=> !powerDown_q)
        else $error("pin input powered down in interrupt mode");

    reset_flag_a: assert property (
        ifc.hwResetActive |=> chipInReset && !powerDown_q)
        else $error("reset status wrong during hardware reset");

    rdata_idle_a: assert property (
        !regRead |=> regRdata == '0)
        else $error("read data not cleared outside read cycle");

    pd_read_a: assert property (
        powerDown_q && regRead && (regAddr == ADDR_PHY_CONTROL) |=>
        regRdata == {11'h000, $past(addr_q)})
        else $error("register read blocked during power-down");

    pd_access_a: assert property (
        powerDown_q && regWrite && (regAddr == ADDR_INTCTL) && !ifc.hwResetActive &&
        !ifc.strapLoad |=> irqMode_q == $past(regWdata[INT_PIN_MODE_BIT]))
        else $error("register write lost during power-down");

    irq_pin_a: assert property (
        irqMode_q && irqPending |=> !pinOeN_q && !pinOut_q ##1 (irqMode_q || pinOeN_q))
        else $error("pending interrupt not driven low on pin");

    sw_reload_a: assert property (
        swReset && !ifc.hwResetActive && !ifc.strapLoad |=> (addr_q == ifc.capAddr) &&
        (adv_q == advertiseFor(ifc.capFxN, ifc.capSelHi, ifc.capSelLo)) && !irqMode_q)
        else $error("software reset did not restore captured straps");

    iso_write_a: assert property (
        regWrite && (regAddr == ADDR_PHY_CONTROL) && !ifc.hwResetActive && !ifc.strapLoad
        |=> $stable(iso_q))
        else $error("address write changed isolation");

    iso_strap_a: assert property (
        ifc.strapLoad |=> iso_q == ($past(ifc.capAddr) == '0))
        else $error("strapped address zero isolation wrong");

    autoneg_a: assert property (
        ifc.strapLoad && ifc.capFxN && ifc.capAnEn |=> anEn_q &&
        (adv_q == advertiseFor(1'b1, $past(ifc.capSelHi), $past(ifc.capSelLo))))
        else $error("autoneg strap not honoured");

    forced_a: assert property (
        ifc.strapLoad && ifc.capFxN && !ifc.capAnEn |=> !anEn_q &&
        (speed_q == $past(ifc.capSelHi)) && (duplex_q == $past(ifc.capSelLo)))
        else $error("forced mode not taken from straps");

    adv_load_a: assert property (
        ifc.strapLoad |=> adv_q == advertiseFor($past(ifc.capFxN), $past(ifc.capSelHi),
        $past(ifc.capSelLo)))
        else $error("strap capability not loaded into advertisement");

    fiber_a: assert property (
        ifc.strapLoad && !ifc.capFxN |=> fiber_q && speed_q && !anEn_q &&
        (duplex_q == $past(ifc.capSelLo)))
        else $error("fiber strap handling wrong");

    fiber_write_a: assert property (
        regWrite && (regAddr == ADDR_BMCR) && fiber_q && !swReset && !ifc.hwResetActive &&
        !ifc.strapLoad |=> !anEn_q && speed_q)
        else $error("register write enabled autoneg in fiber mode");
endmodule
`default_nettype wire

// ---- hw/strap_capture.sv ----
// strap pin synchroniser and capture latch
`timescale 1ns/1ps
`default_nettype none
module strap_capture (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [strap_pkg::STRAP_ADDR_W-1:0] stationAddrStrap,
    input wire logic autonegEnableStrap,
    input wire logic modeSelectStrapHi,
    input wire logic modeSelectStrapLo,
    input wire logic fiberEnableLowStrap,
    strap_if.capture ifc
);
    import strap_pkg::*;
    localparam int VEC_W = STRAP_ADDR_W + 4;
    localparam logic [VEC_W-1:0] VEC_RST = {STRAP_FXN_RST, STRAP_AN_RST, STRAP_ADDR_RST};

    logic [VEC_W-1:0] sync1_q, sync2_q, cap_q, cap_d;
    logic load_q;

    // straps are pins: two stages before the capture latch looks at them
    always_comb begin
        cap_d = cap_q;
        if (ifc.captureStb) begin
            cap_d = sync2_q;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= VEC_RST;
            sync2_q <= VEC_RST;
            cap_q <= VEC_RST;
            load_q <= 1'b0;
        end else begin
            sync1_q <= {fiberEnableLowStrap, autonegEnableStrap, modeSelectStrapHi,
                        modeSelectStrapLo, stationAddrStrap};
            sync2_q <= sync1_q;
            cap_q <= cap_d;
            load_q <= ifc.captureStb;
        end
    end

    assign ifc.strapLoad = load_q;
    assign ifc.capAddr = cap_q[STRAP_ADDR_W-1:0];
    assign ifc.capSelLo = cap_q[STRAP_ADDR_W];
    assign ifc.capSelHi = cap_q[STRAP_ADDR_W+1];
    assign ifc.capAnEn = cap_q[STRAP_ADDR_W+2];
    assign ifc.capFxN = cap_q[STRAP_ADDR_W+3];

    strap_hold_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        !ifc.captureStb |=> $stable(cap_q))
        else $error("strap values changed outside capture");
    strap_take_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        ifc.captureStb |=> (cap_q == $past(sync2_q)) && ifc.strapLoad)
        else $error("strap capture missed sampled value");
endmodule
`default_nettype wire

// ---- pkg/strap_if.sv ----
// internal link between reset qualifier, strap capture and register core
`timescale 1ns/1ps
`default_nettype none
interface strap_if;
    import strap_pkg::*;
    logic hwResetActive;
    logic captureStb;
    logic strapLoad;
    logic [STRAP_ADDR_W-1:0] capAddr;
    logic capAnEn;
    logic capSelHi;
    logic capSelLo;
    logic capFxN;
    modport qualifier (output hwResetActive, output captureStb);
    modport capture (input captureStb, output strapLoad, output capAddr, output capAnEn,
                     output capSelHi, output capSelLo, output capFxN);
    modport core (input hwResetActive, input captureStb, input strapLoad, input capAddr,
                  input capAnEn, input capSelHi, input capSelLo, input capFxN);
endinterface
`default_nettype wire

// ---- pkg/strap_pkg.sv ----
// constants and decode shared by the reset, power-down and strap latch block
// Summary of operation
// - reset pin low 1 us starts reset
// - hardware reset returns every register to default
// - hardware reset resamples and reapplies all straps
// - default pin low means power-down mode
// - registers stay reachable while powered down
// - interrupt mode drives pin low when pending
// - straps captured only at power-up or reset
// - software reset reloads captured straps, no resample
// - five address straps latched, all values accepted
// - strapped address zero isolates; address register write never
// - unstrapped address defaults to one
// - autoneg strap high advertises mode-select capability
// - autoneg strap low forces speed and duplex
// - straps load control and advertisement registers
// - unstrapped autoneg straps default to all ones
// - fiber strap low makes low select duplex
// - fiber mode ignores autoneg enable strap
package strap_pkg;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int RESET_MIN_US = 1;
    localparam int RESET_MIN_CYC = (RESET_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STRAP_SETTLE_CYC = 3;

    localparam int REG_ADDR_W = 5;
    localparam int REG_DATA_W = 16;
    localparam int STRAP_ADDR_W = 5;
    localparam int ADV_W = 4;
    localparam int ANAR_SEL_W = 5;

    localparam logic [REG_ADDR_W-1:0] ADDR_BMCR = 5'h00;
    localparam logic [REG_ADDR_W-1:0] ADDR_ANAR = 5'h04;
    localparam logic [REG_ADDR_W-1:0] ADDR_STATUS = 5'h10;
    localparam logic [REG_ADDR_W-1:0] ADDR_INTCTL = 5'h11;
    localparam logic [REG_ADDR_W-1:0] ADDR_PHY_CONTROL = 5'h19;

    localparam int BMCR_RESET_BIT = 15;
    localparam int BMCR_SPEED_BIT = 13;
    localparam int BMCR_ANEN_BIT = 12;
    localparam int BMCR_PWRDN_BIT = 11;
    localparam int BMCR_ISO_BIT = 10;
    localparam int BMCR_DUPLEX_BIT = 8;

    localparam int ANAR_SEL_LSB = 0;
    localparam int ANAR_CAP_LSB = 5;
    localparam logic [ANAR_SEL_W-1:0] ANAR_SEL = 5'h01;

    localparam int INT_PIN_MODE_BIT = 0;

    localparam int STAT_FIBER_BIT = 0;
    localparam int STAT_PD_BIT = 1;
    localparam int STAT_PDPIN_BIT = 2;
    localparam int STAT_IRQ_BIT = 3;
    localparam int STAT_RESET_BIT = 4;
    localparam int STAT_ADDR_LSB = 8;

    // capability bits: 10HD, 10FD, 100HD, 100FD from lsb up
    localparam logic [ADV_W-1:0] ADV_MODE_00 = 4'h3;
    localparam logic [ADV_W-1:0] ADV_MODE_01 = 4'hC;
    localparam logic [ADV_W-1:0] ADV_MODE_10 = 4'h5;
    localparam logic [ADV_W-1:0] ADV_MODE_11 = 4'hF;
    localparam logic [ADV_W-1:0] ADV_FIBER_HD = 4'h4;
    localparam logic [ADV_W-1:0] ADV_FIBER_FD = 4'h8;

    localparam logic [STRAP_ADDR_W-1:0] STRAP_ADDR_RST = 5'h01;
    localparam logic [2:0] STRAP_AN_RST = 3'h7;
    localparam logic STRAP_FXN_RST = 1'h1;
    localparam logic [1:0] PIN_SYNC_RST = 2'h3;

    function automatic logic [ADV_W-1:0] advertiseFor(input logic fxN, input logic hi,
                                                      input logic lo);
        logic [ADV_W-1:0] cap;
        cap = ADV_MODE_11;
        if (!fxN) begin
            cap = lo ? ADV_FIBER_FD : ADV_FIBER_HD;
        end else begin
            case ({hi, lo})
                2'h0: cap = ADV_MODE_00;
                2'h1: cap = ADV_MODE_01;
                2'h2: cap = ADV_MODE_10;
                default: cap = ADV_MODE_11;
            endcase
        end
        return cap;
    endfunction
endpackage

// ---- verification/reset_powerdown_strap_latch_tb.sv ----
// self-checking bench for the reset, power-down and strap latch block
`timescale 1ns/1ps
`default_nettype none
module reset_powerdown_strap_latch_tb;
    import strap_pkg::*;
    logic clk, arst_n, resetPinN, anEnS, hiS, loS, fxS, padIn, irqPending, pdLow;
    logic [4:0] addrS, regAddr, eA;
    logic [15:0] regWdata, regRdata;
    logic regWrite, regRead, pinOut, pinOeN, chipInReset, powerDown, isolate;
    logic autonegEnable, speed100, fullDuplex, fiberMode, eFx;
    logic [4:0] stationAddr;
    logic [2:0] eAn;
    int err_total, checks, k;
    int capTab[4] = '{3, 12, 5, 15};
    strap_board_model u_strap_board_model (.clk(clk), .resetPinN(resetPinN),
        .addrStrap(addrS), .anEnStrap(anEnS), .selHiStrap(hiS), .selLoStrap(loS),
        .fxNStrap(fxS));
    reset_powerdown_strap_latch u_reset_powerdown_strap_latch (.clk(clk), .arst_n(arst_n),
        .resetPinN(resetPinN), .stationAddrStrap(addrS), .autonegEnableStrap(anEnS),
        .modeSelectStrapHi(hiS), .modeSelectStrapLo(loS), .fiberEnableLowStrap(fxS),
        .powerdownOrIrqPinIn(padIn), .powerdownOrIrqPinOut(pinOut),
        .powerdownOrIrqPinOeN(pinOeN), .irqPending(irqPending), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .chipInReset(chipInReset), .powerDown(powerDown), .isolate(isolate),
        .autonegEnable(autonegEnable), .speed100(speed100), .fullDuplex(fullDuplex),
        .fiberMode(fiberMode), .stationAddr(stationAddr));
    // pad has a pull-up when neither side drives it
    assign padIn = !pinOeN ? pinOut : !pdLow;
    always #4 clk = ~clk;
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e, input string m);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk(regRdata, e, m);
    endtask
    task automatic waitReady();
        for (int i = 0; i < 300 && chipInReset !== 1'b0; i++) @(posedge clk);
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic expectStraps();
        chk(stationAddr, eA, "address");
        chk(isolate, eA == 5'h00, "isolate");
        chk(fiberMode, !eFx, "fiber");
        chk(autonegEnable, eFx & eAn[2], "autoneg");
        if (!eFx || !eAn[2]) chk({speed100, fullDuplex}, {!eFx | eAn[1], eAn[0]}, "forced");
        rd(ADDR_ANAR, {7'h00, 4'(!eFx ? (eAn[0] ? 8 : 4) : capTab[eAn[1:0]]), ANAR_SEL}, "adv");
        rd(ADDR_PHY_CONTROL, {11'h000, eA}, "addr reg");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #(30000 * 8);
        err_total++;
        results();
    end
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        {regAddr, regWdata, regWrite, regRead, irqPending, pdLow} = '0;
        err_total = 0;
        checks = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        waitReady();
        void'($urandom(32'h86a143cc));
        eA = 5'h01;
        eAn = 3'h7;
        eFx = 1'b1;
        expectStraps();
        $display("power-up defaults done");
        for (k = 0; k < 12; k++) begin
            eA = k == 8 ? 5'h00 : k == 9 ? 5'h1F : 5'($urandom_range(1, 31));
            eAn = k >= 10 ? {2'h3, k[0]} : k[2:0];
            eFx = k < 10;
            wr(ADDR_PHY_CONTROL, 16'h0015);
            u_strap_board_model.setStraps(eA, eAn, eFx);
            u_strap_board_model.pulseReset(130);
            waitReady();
            expectStraps();
        end
        $display("strap sweep done");
        wr(ADDR_PHY_CONTROL, 16'h0000);
        #1;
        chk({isolate, stationAddr}, 6'h00, "write zero");
        u_strap_board_model.setStraps(5'h00, 3'h0, 1'b1);
        wr(ADDR_BMCR, 16'h8000);
        repeat (2) @(posedge clk);
        #1;
        chk({isolate, stationAddr}, {1'b0, eA}, "sw reset");
        $display("software reset done");
        wr(ADDR_PHY_CONTROL, 16'h0015);
        u_strap_board_model.pulseReset(60);
        repeat (10) @(posedge clk);
        #1;
        chk(chipInReset, 1'b0, "glitch");
        rd(ADDR_PHY_CONTROL, 16'h0015, "glitch keep");
        $display("short pulse done");
        pdLow <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk(powerDown, 1'b1, "pd pin");
        wr(ADDR_PHY_CONTROL, 16'h0007);
        rd(ADDR_PHY_CONTROL, 16'h0007, "pd access");
        pdLow <= 1'b0;
        wr(ADDR_INTCTL, 16'h0001);
        irqPending <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({pinOeN, pinOut}, 2'h0, "irq low");
        pdLow <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk(powerDown, 1'b0, "irq mode pd");
        irqPending <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(pinOeN, 1'b1, "irq release");
        pdLow <= 1'b0;
        $display("dual pin done");
        results();
    end
endmodule
`default_nettype wire

// ---- verification/strap_board_model.sv ----
// board side: external reset source and strap resistors
`timescale 1ns/1ps
`default_nettype none
module strap_board_model (
    input wire logic clk,
    output logic resetPinN,
    output logic [strap_pkg::STRAP_ADDR_W-1:0] addrStrap,
    output logic anEnStrap,
    output logic selHiStrap,
    output logic selLoStrap,
    output logic fxNStrap
);
    import strap_pkg::*;
    // pull resistors give these levels when nothing is strapped
    initial begin
        resetPinN = 1'b1;
        addrStrap = 5'h01;
        {anEnStrap, selHiStrap, selLoStrap} = 3'h7;
        fxNStrap = 1'b1;
    end
    task automatic setStraps(input logic [4:0] a, input logic [2:0] an, input logic fx);
        @(posedge clk);
        addrStrap <= a;
        {anEnStrap, selHiStrap, selLoStrap} <= an;
        fxNStrap <= fx;
    endtask
    // holds the pin low for cyc clocks, then lets the pull-up take it
    task automatic pulseReset(input int cyc);
        @(posedge clk);
        resetPinN <= 1'b0;
        repeat (cyc) @(posedge clk);
        resetPinN <= 1'b1;
    endtask
endmodule
`default_nettype wire
